/* File: rtl/dpram_host.sv */
// Purpose: Host controller driving one port of a two-port memory with flags.
// Assumes: Device pins sampled synchronously; collision input from the device.
// Notes:   Flag writes put the request bit on data bit 0; array reads wait for collision.
//          Each wait ends on the registered timer flag, which lags its load by a
//          cycle; the guards on the load bit keep a stale flag from ending a phase.
//          The collision input is low while the far side arbitrates against us.
`timescale 1ns/1ns
`include "dpram_host_regs.svh"
module dpram_host (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   input  wire logic                     i_req,
   input  wire dpram_host_pkg::host_op_e i_op,
   input  wire logic [`ADDR_W-1:0]       i_addr,
   input  wire logic [`DATA_W-1:0]       i_wdata,
   input  wire logic                     i_oe_during_wr,
   output logic                          o_ready,
   output logic                          o_done,
   output logic [`DATA_W-1:0]            o_rdata,
   output logic                          o_ce_n,
   output logic                          o_flag_space_select_n,
   output logic                          o_rw_n,
   output logic                          o_oe_n,
   output logic [`ADDR_W-1:0]            o_addr,
   output logic [`DATA_W-1:0]            o_dq_out,
   output logic                          o_dq_oe,
   input  wire logic [`DATA_W-1:0]       i_dq_in,
   input  wire logic                     i_busy_n
);
   import dpram_host_pkg::*;

   // Wait phases in cycles, least times rounded up, never below one
   // One spare cycle each, as the far side sees our pins a clock late
   localparam logic [7:0] CYC_RD  = 8'(`CYC_MIN(`T_AA_NS) + 1);
   localparam logic [7:0] CYC_BDD = 8'(`CYC_MIN(`T_BDD_NS) + 1);
   localparam logic [7:0] CYC_WZ  = 8'(`CYC_MIN(`T_WZ_NS) + 1);
   localparam logic [7:0] CYC_DW  = 8'(`CYC_MIN(`T_DW_NS) + 1);
   localparam logic [7:0] CYC_WP  = 8'(`CYC_MIN(`T_WP_NS) + 1);
   localparam logic [7:0] CYC_REC = 8'(`CYC_MIN(`T_HZ_NS) + `CYC_MIN(`T_SWRD_NS) + 1);

   // Whole controller state in one register; every pin and the timer load
   // come straight out of it, so no output passes through gates
   typedef struct packed {
      host_state_e             st;
      host_op_e                op;
      logic                    oe_wr;
      logic                    busy_seen;
      logic                    ready;
      logic                    done;
      logic [`DATA_W-1:0]      rdata;
      logic                    ce_n;
      logic                    fss_n;
      logic                    rw_n;
      logic                    oe_n;
      logic [`ADDR_W-1:0]      addr;
      logic [`DATA_W-1:0]      dq;
      logic                    dq_oe;
      logic                    tload;
      logic [7:0]              tcount;
   } host_s;

   host_s state_ff;
   host_s nxt_state;
   logic  t_done;

   // Operation is a flag-space access
   function automatic logic is_flag(input host_op_e op);
      is_flag = (op == OP_FLAG_RD) || (op == OP_FLAG_WR);
   endfunction : is_flag

   // Operation writes
   function automatic logic is_write(input host_op_e op);
      is_write = (op == OP_WRITE) || (op == OP_FLAG_WR);
   endfunction : is_write

   // Shared wait timer; its done flag is stale in the cycle after a load
   cycle_timer u_timer (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_load  (state_ff.tload),
      .i_count (state_ff.tcount),
      .o_done  (t_done)
   );

   // Access sequencer
   always_comb begin
      // Hold everything; pulses and the timer load default low
      nxt_state        = state_ff;
      nxt_state.done   = 1'b0;
      nxt_state.tload  = 1'b0;
      nxt_state.tcount = 8'h00;
      unique case (state_ff.st)
         ST_IDLE: begin
            if (i_req) begin
               // Freeze op, address and data for the whole access
               nxt_state.op        = i_op;
               nxt_state.oe_wr     = i_oe_during_wr;
               nxt_state.ready     = 1'b0;
               nxt_state.busy_seen = 1'b0;
               // Address moves only while both strobes are high
               nxt_state.addr      = is_flag(i_op) ?
                  {{(`ADDR_W-`FLAG_SEL_W){1'b0}}, i_addr[`FLAG_SEL_W-1:0]} : i_addr;
               // Flag bit 0 carries request (0) or release (1)
               nxt_state.dq        = is_flag(i_op) ? {{(`DATA_W-1){1'b0}}, i_wdata[0]}
                                                   : i_wdata;
               nxt_state.st        = ST_SETUP;
            end
         end

         ST_SETUP: begin
            // Select pair: array is ce low/flag high, flags the reverse
            // Never both selects low at once
            nxt_state.ce_n  = is_flag(state_ff.op);
            nxt_state.fss_n = !is_flag(state_ff.op);
            if (is_write(state_ff.op)) begin
               // Write strobe falls with select, so device pins stay off
               nxt_state.rw_n   = 1'b0;
               nxt_state.oe_n   = !state_ff.oe_wr;
               nxt_state.tload  = 1'b1;
               nxt_state.tcount = state_ff.oe_wr ? CYC_WZ : 8'h01;
               nxt_state.st     = ST_WRHZ;
            end else begin
               // Read: enable falls with the select, then wait out the access
               nxt_state.oe_n   = 1'b0;
               nxt_state.tload  = 1'b1;
               nxt_state.tcount = CYC_RD;
               nxt_state.st     = ST_RDWAIT;
            end
         end

         ST_RDWAIT: begin
            // Collision on a read adds the release time
            // Flag reads never wait on the collision input
            if (!i_busy_n && !is_flag(state_ff.op)) begin
               nxt_state.busy_seen = 1'b1;
            end
            // Collision gone: restart the wait with the release time
            if (state_ff.busy_seen && i_busy_n && !state_ff.tload) begin
               nxt_state.busy_seen = 1'b0;
               nxt_state.tload     = 1'b1;
               nxt_state.tcount    = CYC_BDD;
            end else if (t_done && !state_ff.tload && !state_ff.busy_seen
                         && (i_busy_n || is_flag(state_ff.op))) begin
               // Address, select and enable times have elapsed, or only the release time after a collision cleared
               nxt_state.rdata  = i_dq_in;
               nxt_state.ce_n   = 1'b1;
               nxt_state.fss_n  = 1'b1;
               nxt_state.oe_n   = 1'b1;
               nxt_state.tload  = 1'b1;
               nxt_state.tcount = CYC_REC;
               nxt_state.st     = ST_RECOV;
            end
         end

         ST_WRHZ: begin
            // Without output enable low the wait is a single cycle
            // Data drive starts only once the device drivers are off
            if (t_done && !state_ff.tload) begin
               nxt_state.dq_oe  = 1'b1;
               nxt_state.tload  = 1'b1;
               nxt_state.tcount = (CYC_DW > CYC_WP) ? CYC_DW : CYC_WP;
               nxt_state.st     = ST_WRDATA;
            end
         end

         ST_WRDATA: begin
            // Selects and address stay put through the strobe
            if (t_done && !state_ff.tload) begin
               // Strobe, selects and enable all rise on one edge
               nxt_state.rw_n   = 1'b1;
               nxt_state.ce_n   = 1'b1;
               nxt_state.fss_n  = 1'b1;
               nxt_state.oe_n   = 1'b1;
               nxt_state.tload  = 1'b1;
               nxt_state.tcount = CYC_REC;
               nxt_state.st     = ST_RECOV;
            end
         end

         ST_RECOV: begin
            // Release data after strobes rise; space out flag write and read
            nxt_state.dq_oe = 1'b0;
            if (t_done && !state_ff.tload) begin
               nxt_state.done  = 1'b1;
               nxt_state.ready = 1'b1;
               nxt_state.st    = ST_IDLE;
            end
         end

         default: begin
            // Illegal one-hot code: back to idle
            nxt_state.st = ST_IDLE;
         end
      endcase
   end

   // State register
   // Synchronous reset; the wait timer resets alongside
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         // Park every strobe high and the data drivers off
         state_ff <= '{st: ST_IDLE, op: OP_READ, oe_wr: 1'b0, busy_seen: 1'b0,
                       ready: 1'b1, done: 1'b0, rdata: '0, ce_n: 1'b1,
                       fss_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: '0, dq: '0,
                       dq_oe: 1'b0, tload: 1'b0, tcount: 8'h00};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from the state register
   assign o_ready               = state_ff.ready;
   assign o_done                = state_ff.done;
   assign o_rdata               = state_ff.rdata;
   assign o_ce_n                = state_ff.ce_n;
   assign o_flag_space_select_n = state_ff.fss_n;
   assign o_rw_n                = state_ff.rw_n;
   assign o_oe_n                = state_ff.oe_n;
   assign o_addr                = state_ff.addr;

   // Data pins: o_dq_oe high while this side drives o_dq_out
   assign o_dq_out              = state_ff.dq;
   assign o_dq_oe               = state_ff.dq_oe;
endmodule : dpram_host

/* File: rtl/dpram_host_regs.svh */
// Purpose: Constants for the host-side two-port memory access controller.
// Assumes: 250 MHz clock, 4 ns period; times in ns.
// Notes:   Counts round each least time up to whole clocks.
`ifndef DPRAM_HOST_REGS_SVH
`define DPRAM_HOST_REGS_SVH
`define CLK_PERIOD_NS   4
`define ADDR_W          13
`define DATA_W          8
`define FLAG_SEL_W      3
`define T_AA_NS         70
`define T_AOE_NS        35
`define T_BDD_NS        45
`define T_WP_NS         50
`define T_WZ_NS         30
`define T_DW_NS         40
`define T_AS_NS         0
`define T_WR_NS         0
`define T_HZ_NS         30
`define T_WDD_NS        95
`define T_SWRD_NS       5
`define T_SOP_NS        15
`define CYC_MIN(t)      (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: rtl/dpram_host_pkg.sv */
// Purpose: Types for the host-side memory access controller.
// Assumes: Constants come from dpram_host_regs.svh.
// Notes:   One-hot states.
package dpram_host_pkg;
   typedef enum logic [1:0] {
      OP_READ      = 2'h0,
      OP_WRITE     = 2'h1,
      OP_FLAG_RD   = 2'h2,
      OP_FLAG_WR   = 2'h3
   } host_op_e;
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_SETUP  = 6'h02,
      ST_RDWAIT = 6'h04,
      ST_WRHZ   = 6'h08,
      ST_WRDATA = 6'h10,
      ST_RECOV  = 6'h20
   } host_state_e;
endpackage : dpram_host_pkg

/* File: rtl/cycle_timer.sv */
// Purpose: Loadable down counter giving wait phases in whole cycles.
// Assumes: Load wins over counting.
// Notes:   o_done is registered and high while the count is zero.
`timescale 1ns/1ns
module cycle_timer (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_load,
   input  wire logic [7:0] i_count,
   output logic            o_done
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       done;
   } timer_s;
   timer_s state_ff;
   timer_s nxt_state;

   // Load or count down toward zero
   always_comb begin
      nxt_state = state_ff;
      if (i_load) begin
         nxt_state.cnt  = i_count;
         nxt_state.done = (i_count == 8'h00);
      end else if (state_ff.cnt != 8'h00) begin
         nxt_state.cnt  = state_ff.cnt - 8'h01;
         nxt_state.done = (state_ff.cnt == 8'h01);
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_ff <= '{cnt: 8'h00, done: 1'b1};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_done = state_ff.done;
endmodule : cycle_timer

/* File: verification/dpram_host_monitor.sv */
// Purpose: Checks the host-side strobe rules of the memory port controller.
// Assumes: Bound to dpram_host; one clock domain.
// Notes:   Pulse widths are counted in whole cycles.
`timescale 1ns/1ns
`include "dpram_host_regs.svh"
module dpram_host_monitor (
   input wire logic               i_clk,
   input wire logic               i_rst_n,
   input wire logic               o_ready,
   input wire logic               o_done,
   input wire logic               o_ce_n,
   input wire logic               o_flag_space_select_n,
   input wire logic               o_rw_n,
   input wire logic               o_oe_n,
   input wire logic [`ADDR_W-1:0] o_addr,
   input wire logic               o_dq_oe
);
   typedef struct packed {
      logic [7:0] low_cnt;
   } mon_state_s;
   mon_state_s st_ff;
   mon_state_s nxt_st;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Cycles the write strobe has been low, saturating
   always_comb begin
      nxt_st = st_ff;
      if (o_rw_n) nxt_st.low_cnt = 8'h00;
      else if (st_ff.low_cnt != 8'hff) nxt_st.low_cnt = st_ff.low_cnt + 8'h01;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) st_ff <= '0;
      else st_ff <= nxt_st;
   end
   // Strobe and handshake relations
   a_select_exclusive: assert property (o_ce_n || o_flag_space_select_n)
      else $error("both spaces selected");
   a_select_held: assert property (!o_rw_n && !$past(o_rw_n) |->
      $stable(o_ce_n) && $stable(o_flag_space_select_n)) else $error("select moved");
   a_addr_quiet: assert property (!$stable(o_addr) |-> (o_rw_n || o_ce_n) &&
      ($past(o_rw_n) || $past(o_ce_n))) else $error("address moved in write");
   a_drive_off_wait: assert property ($fell(o_rw_n) && !o_oe_n |-> !o_dq_oe [*8])
      else $error("data driven before device turn-off");
   a_pulse_width: assert property ($rose(o_rw_n) |->
      st_ff.low_cnt >= ($past(o_oe_n) ? 8'h0d : 8'h12)) else $error("write pulse short");
   a_no_dq_clash: assert property (o_dq_oe |-> o_oe_n || !o_rw_n)
      else $error("data clash");
   a_done_ready: assert property (o_done |-> o_ready && !$past(o_ready))
      else $error("done without busy phase");
endmodule : dpram_host_monitor

/* File: verification/dpram_dev_model.sv */
// Purpose: Behavioural model of one port of the two-port memory with flags.
// Assumes: Pins are sampled on the host clock, one edge late.
// Notes:   Undriven data pins toggle so stale values never pass.
`timescale 1ns/1ns
`include "dpram_host_regs.svh"
module dpram_dev_model (
   input  wire logic               i_clk,
   input  wire logic               i_ce_n,
   input  wire logic               i_flag_space_select_n,
   input  wire logic               i_rw_n,
   input  wire logic               i_oe_n,
   input  wire logic [`ADDR_W-1:0] i_addr,
   input  wire logic [`DATA_W-1:0] i_dq_out,
   input  wire logic               i_dq_oe,
   input  wire logic               i_busy_hold,
   input  wire logic [7:0]         i_other_hold,
   output logic      [`DATA_W-1:0] o_dq_in,
   output logic                    o_busy_n
);
   logic [`DATA_W-1:0] mem_ff [0:(1<<`ADDR_W)-1];
   logic [7:0]         held_ff;
   logic               arr_wr_ff;
   logic               flg_wr_ff;
   logic [`DATA_W-1:0] wdat_ff;
   int                 rd_cnt;
   int                 free_cnt;
   logic               arr_sel;
   logic               flg_sel;
   logic               rd_on;
   logic               ok;
   // Space decode, read enable and access-time gate
   assign arr_sel = !i_ce_n && i_flag_space_select_n;
   assign flg_sel = i_ce_n && !i_flag_space_select_n;
   assign rd_on   = (arr_sel || flg_sel) && i_rw_n && !i_oe_n;
   assign ok      = rd_cnt >= `CYC_MIN(`T_AA_NS) - 1 &&
                    (flg_sel || free_cnt >= `CYC_MIN(`T_BDD_NS) - 1);
   initial begin
      held_ff  = 8'h00;
      rd_cnt   = 0;
      free_cnt = 0;
      o_dq_in  = 8'h00;
      o_busy_n = 1'b1;
   end
   // Writes commit on the edge that ends them; reads drive after access time
   always @(posedge i_clk) begin
      o_busy_n  <= !i_busy_hold;
      free_cnt  <= o_busy_n ? free_cnt + 1 : 0;
      rd_cnt    <= rd_on ? rd_cnt + 1 : 0;
      arr_wr_ff <= arr_sel && !i_rw_n;
      flg_wr_ff <= flg_sel && !i_rw_n;
      if (i_dq_oe) wdat_ff <= i_dq_out;
      if (arr_wr_ff && !(arr_sel && !i_rw_n) && o_busy_n) mem_ff[i_addr] <= wdat_ff;
      if (flg_wr_ff && !(flg_sel && !i_rw_n) && !i_other_hold[i_addr[2:0]])
         held_ff[i_addr[2:0]] <= !wdat_ff[0];
      if (rd_on && ok) o_dq_in <= flg_sel ? {8{!held_ff[i_addr[2:0]]}} : mem_ff[i_addr];
      else o_dq_in <= ~o_dq_in;
   end
endmodule : dpram_dev_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the host memory port controller.
// Assumes: Device model on the far side; busy and foreign flags steered here.
// Notes:   Each scenario drives accesses and judges the result; sc_reset cuts one read short with reset.
`timescale 1ns/1ns
`include "dpram_host_regs.svh"
module tb_top;
   import dpram_host_pkg::*;
   logic               clk;
   logic               rst_n;
   logic               req;
   host_op_e           op;
   logic [`ADDR_W-1:0] addr;
   logic [`DATA_W-1:0] wdata;
   logic               oe_wr;
   logic               ready;
   logic               done;
   logic [`DATA_W-1:0] rdata;
   logic               ce_n;
   logic               fss_n;
   logic               rw_n;
   logic               oe_n;
   logic [`ADDR_W-1:0] pin_addr;
   logic [`DATA_W-1:0] dq_out;
   logic               dq_oe;
   logic [`DATA_W-1:0] dq_in;
   logic               busy_n;
   logic               busy_hold;
   logic [7:0]         other_hold;
   int                 num_errors;
   int                 n_compared;
   dpram_host uut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_op(op), .i_addr(addr),
      .i_wdata(wdata), .i_oe_during_wr(oe_wr), .o_ready(ready), .o_done(done), .o_rdata(rdata),
      .o_ce_n(ce_n), .o_flag_space_select_n(fss_n), .o_rw_n(rw_n), .o_oe_n(oe_n),
      .o_addr(pin_addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_in), .i_busy_n(busy_n));
   dpram_dev_model dev (.i_clk(clk), .i_ce_n(ce_n), .i_flag_space_select_n(fss_n),
      .i_rw_n(rw_n), .i_oe_n(oe_n), .i_addr(pin_addr), .i_dq_out(dq_out), .i_dq_oe(dq_oe),
      .i_busy_hold(busy_hold), .i_other_hold(other_hold), .o_dq_in(dq_in), .o_busy_n(busy_n));
   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // One access: request for one edge, then wait for the done pulse
   task automatic do_op(input host_op_e o, input logic [12:0] a, input logic [7:0] d,
                        input logic oe, output logic [7:0] rd, output int cyc);
      @(posedge clk);
      req   <= 1'b1;
      op    <= o;
      addr  <= a;
      wdata <= d;
      oe_wr <= oe;
      @(posedge clk);
      req <= 1'b0;
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while (done !== 1'b1 && cyc < 400);
      if (cyc >= 400) check("done timeout", 8'h00, 8'h01);
      rd = rdata;
   endtask : do_op
   task automatic sc_array();
      logic [7:0] rd;
      int         cyc;
      do_op(OP_WRITE, 13'h1fff, 8'h5a, 1'b0, rd, cyc);
      do_op(OP_WRITE, 13'h0000, 8'ha5, 1'b1, rd, cyc);
      do_op(OP_READ, 13'h1fff, 8'h00, 1'b0, rd, cyc);
      check("array top", rd, 8'h5a);
      do_op(OP_READ, 13'h0000, 8'h00, 1'b0, rd, cyc);
      check("array bottom", rd, 8'ha5);
   endtask : sc_array
   task automatic sc_busy();
      logic [7:0] rd;
      int         cyc;
      busy_hold <= 1'b1;
      do_op(OP_WRITE, 13'h1fff, 8'h77, 1'b0, rd, cyc);
      fork
         do_op(OP_READ, 13'h1fff, 8'h00, 1'b0, rd, cyc);
         begin
            repeat (40) @(posedge clk);
            busy_hold <= 1'b0;
         end
      join
      check("blocked write", rd, 8'h5a);
      check("collision wait", {7'h00, cyc >= 40 + `CYC_MIN(`T_BDD_NS)}, 8'h01);
   endtask : sc_busy
   // Mid-run reset: a read cut short leaves every strobe parked high
   task automatic sc_reset();
      logic [7:0] rd;
      int         cyc;
      @(posedge clk);
      req  <= 1'b1;
      op   <= OP_READ;
      addr <= 13'h1fff;
      @(posedge clk);
      req <= 1'b0;
      repeat (6) @(posedge clk);
      check("read select", {6'h00, ce_n, fss_n}, 8'h01);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("reset strobes", {4'h0, ce_n, fss_n, rw_n, oe_n}, 8'h0f);
      check("reset drive", {6'h00, ready, dq_oe}, 8'h02);
      rst_n <= 1'b1;
      do_op(OP_READ, 13'h1fff, 8'h00, 1'b0, rd, cyc);
      check("read after reset", rd, 8'h5a);
   endtask : sc_reset
   task automatic sc_flags();
      logic [7:0] rd;
      int         cyc;
      do_op(OP_FLAG_RD, 13'h0005, 8'h00, 1'b0, rd, cyc);
      check("flag free", rd, 8'hff);
      do_op(OP_FLAG_WR, 13'h0005, 8'hfe, 1'b0, rd, cyc);
      do_op(OP_FLAG_RD, 13'h0005, 8'h00, 1'b0, rd, cyc);
      check("flag held", rd, 8'h00);
      do_op(OP_FLAG_RD, 13'h0004, 8'h00, 1'b0, rd, cyc);
      check("neighbour flag", rd, 8'hff);
      do_op(OP_FLAG_WR, 13'h0005, 8'h01, 1'b0, rd, cyc);
      do_op(OP_FLAG_RD, 13'h0005, 8'h00, 1'b0, rd, cyc);
      check("flag released", rd, 8'hff);
   endtask : sc_flags
   task automatic sc_flag_other();
      logic [7:0] rd;
      int         cyc;
      other_hold <= 8'h80;
      do_op(OP_FLAG_WR, 13'h0007, 8'h00, 1'b1, rd, cyc);
      do_op(OP_FLAG_RD, 13'h0007, 8'h00, 1'b0, rd, cyc);
      check("foreign flag", rd, 8'hff);
      other_hold <= 8'h00;
      do_op(OP_FLAG_WR, 13'h0007, 8'h00, 1'b1, rd, cyc);
      do_op(OP_FLAG_RD, 13'h0007, 8'h00, 1'b0, rd, cyc);
      check("flag claimed", rd, 8'h00);
   endtask : sc_flag_other
   // Watchdog: far beyond the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      num_errors = 0;
      n_compared = 0;
      rst_n      = 1'b0;
      req        = 1'b0;
      op         = OP_READ;
      addr       = '0;
      wdata      = '0;
      oe_wr      = 1'b0;
      busy_hold  = 1'b0;
      other_hold = 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      sc_array();
      sc_busy();
      sc_reset();
      sc_flags();
      sc_flag_other();
      print_verdict();
   end
endmodule : tb_top
bind dpram_host dpram_host_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_ready(o_ready),
   .o_done(o_done), .o_ce_n(o_ce_n), .o_flag_space_select_n(o_flag_space_select_n),
   .o_rw_n(o_rw_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq_oe(o_dq_oe));
